// ==== hdl/rps_pkg.sv ====
// constants, field layout and state codes of the rail power sequencer
package rps_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int N_RAIL = 12;
	localparam int N_GRP  = 6;
	localparam int N_PG   = 4;
	localparam int CFG_W  = 22;
	localparam int VC_W   = 15;
	localparam int PGC_W  = 19;
	localparam int GPO_W  = 10;
	localparam int SYNC_W = 22;
	localparam int TCK_W  = 17;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS     = 10;
	localparam int MS_NS      = 1000000;
	localparam int MS_CYC     = MS_NS / CLK_NS;
	localparam int UV_DLY_NS  = 444;
	localparam int UV_DLY_CYC = UV_DLY_NS / CLK_NS;
	localparam int PG_TMO_MS  = 10;
	localparam int OTP_CYC    = 8;
	localparam logic [6:0] PGD1_MAX = 7'h0F;
	localparam logic [6:0] PGD3_MIN = 7'h05;
	localparam logic [6:0] PGD_MAX  = 7'h64;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] A_RAIL_CFG = 8'h00;
	localparam logic [7:0] A_RAIL_VC  = 8'h10;
	localparam logic [7:0] A_PG_CFG   = 8'h20;
	localparam logic [7:0] A_GPO_CTL  = 8'h24;
	localparam logic [7:0] A_STATUS   = 8'h28;
	localparam logic [7:0] A_PG_STAT  = 8'h29;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int F_GRP   = 0;
	localparam int F_SRC   = 3;
	localparam int F_END   = 7;
	localparam int F_DIS   = 11;
	localparam int F_DECAY = 15;
	localparam int F_SLP   = 16;
	localparam int F_SWEN  = 18;
	localparam int F_SWOFF = 19;
	localparam int F_LOSS  = 20;
	localparam int F_TMO   = 21;
	localparam int F_SCODE = 8;
	localparam int F_PGDLY = 12;
	localparam int F_LVL   = 4;
	localparam int F_C3SLP = 8;
	localparam int F_C6SLP = 9;
	localparam int F_ST    = 12;
	localparam int F_CAUSE = 16;
	localparam int S_CTL   = 0;
	localparam int S_PG    = 6;
	localparam int S_SGOOD = 18;
	localparam int S_SLOW  = 19;
	localparam int S_TCRIT = 20;
	localparam int S_TCOOL = 21;
	localparam logic [3:0] SRC_NONE = 4'hF;
	localparam logic [1:0] SLP_C3   = 2'h1;
	localparam logic [1:0] SLP_C6   = 2'h2;
	localparam int CTL3 = 2;
	localparam int CTL6 = 5;
	// ------------------------------------------------------------
	// defaults loaded by the reload step
	// ------------------------------------------------------------
	localparam logic [CFG_W-1:0] CFG_RST = 22'h000078;
	localparam logic [VC_W-1:0]  VC_RST  = 15'h0000;
	localparam logic [PGC_W-1:0] PGC_RST = 19'h00000;
	localparam logic [GPO_W-1:0] GPO_RST = 10'h000;
	// ------------------------------------------------------------
	// modes and shutdown causes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF     = 3'h0,
		ST_RELOAD  = 3'h1,
		ST_STANDBY = 3'h3,
		ST_ACTIVE  = 3'h2,
		ST_SHUT    = 3'h6,
		ST_WAIT    = 3'h7
	} rps_state_type;
	typedef enum logic [1:0] {
		C_NONE  = 2'h0,
		C_UV    = 2'h1,
		C_THERM = 2'h2,
		C_FAULT = 2'h3
	} rps_cause_type;
endpackage : rps_pkg

// ==== hdl/rps_rail_power_sequencer.sv ====
// rail enable sequencing, power-good outputs and shutdown supervision
`timescale 1ns/1ps
`default_nettype none
// Contract
// - power-good delay ranges per output
// - power-good output ANDs its member rails
// - general outputs drivable by software level
// - enable from pin, prior power good, software
// - software enable or disable overrides sequencing
// - six group pins, each rail joins at most one
// - sleep pins select sleep voltage code
// - wait all conditions, then enable delay
// - independent disable delay per rail
// - sleeping rail decays or slews per select
// - undervoltage drops outputs, rails off 44 cycles (440ns) later
// - shutdown selects 100 ohm discharge
// - thermal, power-good loss, timeout shut down
// - undervoltage waits supply, reloads, restarts
// - thermal waits cooling, reloads, restarts
// - fault disables, reloads, then restarts
// - off mode keeps every rail disabled
// - standby only after defaults are loaded
// - in standby or active, any rail enabled means active mode
// - voltage code write retargets rail
module rps_rail_power_sequencer #(
	parameter int MS_CYCLES = rps_pkg::MS_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wr_data,
	output logic      [31:0] rd_data,
	input  wire logic [5:0]  group_control_input,
	input  wire logic [11:0] rail_power_good,
	input  wire logic        supply_good,
	input  wire logic        supply_low,
	input  wire logic        temp_critical,
	input  wire logic        temp_cooled,
	output logic      [11:0] rail_enable,
	output logic [11:0][6:0] rail_voltage_code,
	output logic      [11:0] rail_decay_select,
	output logic             discharge_100ohm,
	output logic      [3:0]  general_output,
	output logic      [2:0]  device_mode,
	output logic             interface_ready
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	localparam int UVD = rps_pkg::UV_DLY_CYC;
	localparam int NR  = rps_pkg::N_RAIL;
	localparam int NP  = rps_pkg::N_PG;
	typedef struct packed {
		rps_pkg::rps_state_type             st;
		rps_pkg::rps_cause_type             cause;
		logic [rps_pkg::SYNC_W-1:0]         sync1;
		logic [rps_pkg::SYNC_W-1:0]         sync2;
		logic [rps_pkg::TCK_W-1:0]          tcnt;
		logic                               tick;
		logic [6:0]                         wcnt;
		logic [NR-1:0][rps_pkg::CFG_W-1:0]  cfg;
		logic [NR-1:0][rps_pkg::VC_W-1:0]   vc;
		logic [NP-1:0][rps_pkg::PGC_W-1:0]  pgc;
		logic [rps_pkg::GPO_W-1:0]          gpo;
		logic [NR-1:0]                      en;
		logic [NR-1:0]                      pgh;
		logic [NR-1:0][3:0]                 rcnt;
		logic [NR-1:0][3:0]                 ocnt;
		logic [NP-1:0][6:0]                 pcnt;
		logic [NP-1:0]                      pgo;
		logic [NR-1:0][6:0]                 vout;
		logic [NR-1:0]                      dec;
		logic                               dis;
		logic [31:0]                        rdat;
	} rps_core_type;
	rps_core_type                state_ff;
	rps_core_type                nxt_state;
	logic [5:0]                  ctl;
	logic [NR-1:0]               pg;
	logic                        ready;
	logic                        act;
	logic [NR-1:0]               slp_v;
	logic [NP-1:0]               tree_v;
	logic                        flt;
	logic                        want;
	logic [3:0]                  dly;
	logic [6:0]                  pgd;
	logic [rps_pkg::CFG_W-1:0]   c;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic grp_ok(input logic [5:0] v,
		input logic [2:0] g);
		if (g == 3'h0)
			return 1'b1;
		if (g > 3'h6)
			return 1'b0;
		return v[g - 3'h1];
	endfunction : grp_ok
	function automatic logic src_ok(input logic [11:0] v,
		input logic [3:0] s);
		if (s == rps_pkg::SRC_NONE)
			return 1'b1;
		if (s > 4'hB)
			return 1'b0;
		return v[s];
	endfunction : src_ok
	// limits differ per output; out-of-range codes saturate
	function automatic logic [6:0] pg_clamp(input int k,
		input logic [6:0] d);
		if (k == 0 && d > rps_pkg::PGD1_MAX)
			return rps_pkg::PGD1_MAX;
		if (k == 2 && d < rps_pkg::PGD3_MIN)
			return rps_pkg::PGD3_MIN;
		if (d > rps_pkg::PGD_MAX)
			return rps_pkg::PGD_MAX;
		return d;
	endfunction : pg_clamp
	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	assign ctl   = state_ff.sync2[rps_pkg::S_CTL +: 6];
	assign pg    = state_ff.sync2[rps_pkg::S_PG +: NR];
	assign act   = state_ff.st == rps_pkg::ST_ACTIVE;
	assign ready = act || state_ff.st == rps_pkg::ST_STANDBY;
	always_comb begin
		nxt_state = state_ff;
		slp_v = '0;
		tree_v = '0;
		flt = 1'b0;
		want = 1'b0;
		dly = 4'h0;
		pgd = 7'h00;
		c = '0;
		nxt_state.sync1 = {temp_cooled, temp_critical, supply_low,
			supply_good, rail_power_good, group_control_input};
		nxt_state.sync2 = state_ff.sync1;
		// millisecond timebase
		nxt_state.tick = 1'b0;
		nxt_state.tcnt = state_ff.tcnt + 1'b1;
		if (state_ff.tcnt == rps_pkg::TCK_W'(MS_CYCLES - 1)) begin
			nxt_state.tcnt = '0;
			nxt_state.tick = 1'b1;
		end
		// writes are taken only once defaults are in place
		if (wr_en && ready) begin
			for (int i = 0; i < NR; i++) begin
				if (addr == 8'(rps_pkg::A_RAIL_CFG + i))
					nxt_state.cfg[i] = wr_data[rps_pkg::CFG_W-1:0];
				if (addr == 8'(rps_pkg::A_RAIL_VC + i))
					nxt_state.vc[i] = wr_data[rps_pkg::VC_W-1:0];
			end
			for (int k = 0; k < NP; k++) begin
				if (addr == 8'(rps_pkg::A_PG_CFG + k))
					nxt_state.pgc[k] = wr_data[rps_pkg::PGC_W-1:0];
			end
			if (addr == rps_pkg::A_GPO_CTL)
				nxt_state.gpo = wr_data[rps_pkg::GPO_W-1:0];
		end
		// reads answer one cycle later, zero when unmapped
		nxt_state.rdat = '0;
		if (rd_en) begin
			for (int i = 0; i < NR; i++) begin
				if (addr == 8'(rps_pkg::A_RAIL_CFG + i))
					nxt_state.rdat = 32'(state_ff.cfg[i]);
				if (addr == 8'(rps_pkg::A_RAIL_VC + i))
					nxt_state.rdat = 32'(state_ff.vc[i]);
			end
			for (int k = 0; k < NP; k++) begin
				if (addr == 8'(rps_pkg::A_PG_CFG + k))
					nxt_state.rdat = 32'(state_ff.pgc[k]);
			end
			if (addr == rps_pkg::A_GPO_CTL)
				nxt_state.rdat = 32'(state_ff.gpo);
			if (addr == rps_pkg::A_STATUS) begin
				nxt_state.rdat[NR-1:0] = state_ff.en;
				nxt_state.rdat[rps_pkg::F_ST +: 3] = state_ff.st;
				nxt_state.rdat[rps_pkg::F_CAUSE +: 2] = state_ff.cause;
			end
			if (addr == rps_pkg::A_PG_STAT) begin
				nxt_state.rdat[NR-1:0] = pg;
				nxt_state.rdat[NR +: NP] = state_ff.pgo;
			end
		end
		// sleep pins are active low and only count when enabled
		for (int i = 0; i < NR; i++) begin
			c = state_ff.cfg[i];
			slp_v[i] = (c[rps_pkg::F_SLP +: 2] == rps_pkg::SLP_C3 &&
				state_ff.gpo[rps_pkg::F_C3SLP] && !ctl[rps_pkg::CTL3]) ||
				(c[rps_pkg::F_SLP +: 2] == rps_pkg::SLP_C6 &&
				state_ff.gpo[rps_pkg::F_C6SLP] && !ctl[rps_pkg::CTL6]);
			nxt_state.vout[i] = slp_v[i] ?
				state_ff.vc[i][rps_pkg::F_SCODE +: 7] :
				state_ff.vc[i][6:0];
			nxt_state.dec[i] = slp_v[i] && c[rps_pkg::F_DECAY];
		end
		for (int k = 0; k < NP; k++) begin
			tree_v[k] = &(pg | ~state_ff.pgc[k][NR-1:0]) &&
				|state_ff.pgc[k][NR-1:0];
		end
		if (!ready) begin
			nxt_state.rcnt = '0;
			nxt_state.ocnt = '0;
			nxt_state.pcnt = '0;
			nxt_state.pgo = '0;
		end
		case (state_ff.st)
			rps_pkg::ST_OFF: begin
				nxt_state.en = '0;
				nxt_state.wcnt = '0;
				if (state_ff.sync2[rps_pkg::S_SGOOD])
					nxt_state.st = rps_pkg::ST_RELOAD;
			end
			rps_pkg::ST_RELOAD: begin
				nxt_state.en = '0;
				nxt_state.dis = 1'b0;
				nxt_state.cfg = {NR{rps_pkg::CFG_RST}};
				nxt_state.vc = {NR{rps_pkg::VC_RST}};
				nxt_state.pgc = {NP{rps_pkg::PGC_RST}};
				nxt_state.gpo = rps_pkg::GPO_RST;
				nxt_state.wcnt = state_ff.wcnt + 1'b1;
				if (!state_ff.sync2[rps_pkg::S_SGOOD])
					nxt_state.st = rps_pkg::ST_OFF;
				else if (state_ff.wcnt == 7'(rps_pkg::OTP_CYC - 1))
					nxt_state.st = rps_pkg::ST_STANDBY;
			end
			rps_pkg::ST_STANDBY, rps_pkg::ST_ACTIVE: begin
				for (int i = 0; i < NR; i++) begin
					c = state_ff.cfg[i];
					want = !c[rps_pkg::F_SWOFF] && (c[rps_pkg::F_SWEN] ||
						((c[rps_pkg::F_GRP +: 3] != 3'h0 ||
						c[rps_pkg::F_SRC +: 4] != rps_pkg::SRC_NONE) &&
						grp_ok(ctl, c[rps_pkg::F_GRP +: 3]) &&
						src_ok(pg, c[rps_pkg::F_SRC +: 4])));
					dly = want ? c[rps_pkg::F_END +: 4] :
						c[rps_pkg::F_DIS +: 4];
					if (want != state_ff.en[i]) begin
						if (state_ff.rcnt[i] >= dly) begin
							nxt_state.en[i] = want;
							nxt_state.rcnt[i] = 4'h0;
						end else if (state_ff.tick)
							nxt_state.rcnt[i] = state_ff.rcnt[i] + 1'b1;
					end else
						nxt_state.rcnt[i] = 4'h0;
					// power-good timeout and loss, each optional
					if (state_ff.en[i] && !pg[i] && c[rps_pkg::F_TMO]) begin
						if (state_ff.ocnt[i] >= 4'(rps_pkg::PG_TMO_MS))
							flt = 1'b1;
						else if (state_ff.tick)
							nxt_state.ocnt[i] = state_ff.ocnt[i] + 1'b1;
					end else
						nxt_state.ocnt[i] = 4'h0;
					// loss only counts once the rail has shown good
					if (state_ff.en[i] && state_ff.pgh[i] && !pg[i] &&
						c[rps_pkg::F_LOSS])
						flt = 1'b1;
				end
				for (int k = 0; k < NP; k++) begin
					pgd = pg_clamp(k, state_ff.pgc[k][rps_pkg::F_PGDLY +: 7]);
					if (state_ff.gpo[k])
						nxt_state.pgo[k] = state_ff.gpo[rps_pkg::F_LVL + k];
					else if (tree_v[k]) begin
						if (!state_ff.pgo[k]) begin
							if (state_ff.pcnt[k] >= pgd)
								nxt_state.pgo[k] = 1'b1;
							else if (state_ff.tick)
								nxt_state.pcnt[k] = state_ff.pcnt[k] + 1'b1;
						end
					end else begin
						nxt_state.pgo[k] = 1'b0;
						nxt_state.pcnt[k] = 7'h00;
					end
				end
				nxt_state.wcnt = '0;
				if (state_ff.sync2[rps_pkg::S_SLOW]) begin
					nxt_state.st = rps_pkg::ST_SHUT;
					nxt_state.cause = rps_pkg::C_UV;
					nxt_state.pgo = '0;
				end else if (state_ff.sync2[rps_pkg::S_TCRIT]) begin
					nxt_state.st = rps_pkg::ST_SHUT;
					nxt_state.cause = rps_pkg::C_THERM;
					nxt_state.pgo = '0;
				end else if (flt) begin
					nxt_state.st = rps_pkg::ST_SHUT;
					nxt_state.cause = rps_pkg::C_FAULT;
					nxt_state.pgo = '0;
				end else if (|nxt_state.en)
					nxt_state.st = rps_pkg::ST_ACTIVE;
				else
					nxt_state.st = rps_pkg::ST_STANDBY;
			end
			rps_pkg::ST_SHUT: begin
				// rails keep running through the short hold-off
				nxt_state.wcnt = state_ff.wcnt + 1'b1;
				if (state_ff.wcnt == 7'(UVD - 1)) begin
					nxt_state.en = '0;
					nxt_state.dis = 1'b1;
					nxt_state.st = rps_pkg::ST_WAIT;
				end
			end
			rps_pkg::ST_WAIT: begin
				nxt_state.en = '0;
				nxt_state.wcnt = '0;
				if (state_ff.cause == rps_pkg::C_UV ||
					!state_ff.sync2[rps_pkg::S_SGOOD])
					nxt_state.st = rps_pkg::ST_OFF;
				else if (state_ff.cause == rps_pkg::C_FAULT)
					nxt_state.st = rps_pkg::ST_RELOAD;
				else if (state_ff.sync2[rps_pkg::S_TCOOL])
					nxt_state.st = rps_pkg::ST_RELOAD;
			end
			default: nxt_state.st = rps_pkg::ST_OFF;
		endcase
		nxt_state.pgh = state_ff.en & (state_ff.pgh | pg);
	end
	// ------------------------------------------------------------
	// registers and outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end
	assign rd_data           = state_ff.rdat;
	assign rail_enable       = state_ff.en;
	assign rail_voltage_code = state_ff.vout;
	assign rail_decay_select = state_ff.dec;
	assign discharge_100ohm  = state_ff.dis;
	assign general_output    = state_ff.pgo;
	assign device_mode       = state_ff.st;
	assign interface_ready   = ready;
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_uv_pg;
		ready && state_ff.sync2[rps_pkg::S_SLOW] |=> general_output == '0;
	endproperty
	a_uv_pg: assert property (p_uv_pg) else $error("pg kept on uv");
	property p_uv_off;
		$rose(state_ff.st == rps_pkg::ST_SHUT) |->
			##UVD (rail_enable == '0 && state_ff.st == rps_pkg::ST_WAIT);
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("rails late");
	property p_dis;
		state_ff.st == rps_pkg::ST_WAIT |-> discharge_100ohm;
	endproperty
	a_dis: assert property (p_dis) else $error("no discharge");
	property p_off;
		state_ff.st == rps_pkg::ST_OFF |-> rail_enable == '0;
	endproperty
	a_off: assert property (p_off) else $error("rail on in off");
	property p_act;
		ready && |rail_enable |-> act;
	endproperty
	a_act: assert property (p_act) else $error("not active");
	property p_vc;
		wr_en && ready && addr == rps_pkg::A_RAIL_VC |-> ##2
			$past(slp_v[0]) || rail_voltage_code[0] == $past(wr_data[6:0], 2);
	endproperty
	a_vc: assert property (p_vc) else $error("code not applied");
	property p_slp;
		slp_v[0] |=> rail_voltage_code[0] ==
			$past(state_ff.vc[0][rps_pkg::F_SCODE +: 7]);
	endproperty
	a_slp: assert property (p_slp) else $error("sleep code");
	property p_sw;
		ready && state_ff.gpo[0] && !state_ff.sync2[rps_pkg::S_SLOW] &&
			!state_ff.sync2[rps_pkg::S_TCRIT] && !flt |=>
			general_output[0] == $past(state_ff.gpo[rps_pkg::F_LVL]);
	endproperty
	a_sw: assert property (p_sw) else $error("gpo level");
	property p_tmp;
		ready && state_ff.sync2[rps_pkg::S_TCRIT] |=>
			state_ff.st == rps_pkg::ST_SHUT;
	endproperty
	a_tmp: assert property (p_tmp) else $error("no thermal stop");
	property p_tree;
		$rose(general_output[0]) && !state_ff.gpo[0] |-> $past(tree_v[0]);
	endproperty
	a_tree: assert property (p_tree) else $error("pg without tree");
endmodule : rps_rail_power_sequencer
`default_nettype wire

// ==== hdl/unused_placeholder_none.sv ====
// intentionally empty design unit list
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verif/rps_ctl_model.sv ====
// controller and regulator stand-in facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module rps_ctl_model #(
	parameter int PG_LAT = 4
) (
	input  wire logic        clk_sys,
	input  wire logic        supply_good,
	input  wire logic [5:0]  pin_req,
	input  wire logic [11:0] pg_stuck,
	input  wire logic [11:0] rail_enable,
	output logic      [5:0]  group_control_input,
	output logic      [11:0] rail_power_good
);
	logic [PG_LAT-1:0][11:0] pg_pipe_ff;

	always @(posedge clk_sys) begin
		// no pin is raised before the supply is valid
		group_control_input <= supply_good ? pin_req : 6'h00;
		pg_pipe_ff <= {pg_pipe_ff[PG_LAT-2:0], rail_enable};
	end

	// unpowered rail reads not good; stuck mask models a failing rail
	assign rail_power_good = pg_pipe_ff[PG_LAT-1] & ~pg_stuck;
endmodule : rps_ctl_model
`default_nettype wire

// ==== verif/rail_power_sequencer_bench.sv ====
// self-checking bench of the rail power sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
	error_cnt++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
`define WAIT_UNTIL(c, n) begin cnt = 0; while (!(c) && cnt < (n)) begin \
	@(posedge clk_sys); #1; cnt++; end end
module rail_power_sequencer_bench;
	localparam int MS = 20;
	logic             clk_sys = 1'b0;
	logic             rst = 1'b1;
	logic             wr_en = 1'b0;
	logic             rd_en = 1'b0;
	logic [7:0]       addr = 8'h00;
	logic [31:0]      wr_data = 32'h00000000;
	logic [31:0]      rd_data;
	logic             supply_good = 1'b1;
	logic             supply_low = 1'b0;
	logic             temp_critical = 1'b0;
	logic             temp_cooled = 1'b0;
	logic [5:0]       pin_req = 6'h00;
	logic [11:0]      pg_stuck = 12'h000;
	logic [5:0]       group_control_input;
	logic [11:0]      rail_power_good;
	logic [11:0]      rail_enable;
	logic [11:0][6:0] rail_voltage_code;
	logic [11:0]      rail_decay_select;
	logic             discharge_100ohm;
	logic [3:0]       general_output;
	logic [2:0]       device_mode;
	logic             interface_ready;
	int               error_cnt = 0;
	int               tests_run = 0;
	int               cnt;
	logic [31:0]      rv;

	always #5 clk_sys = ~clk_sys;

	rps_rail_power_sequencer #(.MS_CYCLES(MS)) dut_u (
		.clk_sys(clk_sys), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wr_data(wr_data), .rd_data(rd_data),
		.group_control_input(group_control_input),
		.rail_power_good(rail_power_good), .supply_good(supply_good),
		.supply_low(supply_low), .temp_critical(temp_critical),
		.temp_cooled(temp_cooled), .rail_enable(rail_enable),
		.rail_voltage_code(rail_voltage_code),
		.rail_decay_select(rail_decay_select),
		.discharge_100ohm(discharge_100ohm),
		.general_output(general_output), .device_mode(device_mode),
		.interface_ready(interface_ready)
	);

	rps_ctl_model #(.PG_LAT(4)) model_u (
		.clk_sys(clk_sys), .supply_good(supply_good), .pin_req(pin_req),
		.pg_stuck(pg_stuck), .rail_enable(rail_enable),
		.group_control_input(group_control_input),
		.rail_power_good(rail_power_good)
	);

	// ------------------------------------------------------------
	// register bus and closing
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask : rd

	task automatic tally_and_finish();
		if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_standby();
		`WAIT_UNTIL(device_mode == rps_pkg::ST_STANDBY, 40)
		`CHK("ready", 1'b1, interface_ready)
		`CHK("enables", 12'h000, rail_enable)
		rd(8'h00, rv);
		`CHK("cfg0", 32'h00000078, rv)
		rd(8'h30, rv);
		`CHK("unmapped", 32'h00000000, rv)
	endtask : t_standby

	task automatic t_seq();
		wr(8'h00, 32'h00000079);
		wr(8'h01, 32'h00000102);
		@(posedge clk_sys) pin_req <= 6'h02;
		repeat (60) @(posedge clk_sys);
		#1;
		`CHK("early pin", 12'h000, rail_enable)
		@(posedge clk_sys) pin_req <= 6'h03;
		`WAIT_UNTIL(rail_enable[0], 10)
		`CHK("group one", 12'h001, rail_enable)
		`CHK("active", rps_pkg::ST_ACTIVE, device_mode)
		`WAIT_UNTIL(rail_enable[1], 100)
		`CHK("pg chain", 1'b1, rail_enable[1] && cnt >= MS)
	endtask : t_seq

	task automatic t_sleep();
		@(posedge clk_sys) pin_req <= 6'h07;
		wr(8'h10, 32'h0000152A);
		wr(8'h00, 32'h00018079);
		wr(8'h24, 32'h00000100);
		#1;
		`CHK("normal code", 7'h2A, rail_voltage_code[0])
		@(posedge clk_sys) pin_req <= 6'h03;
		`WAIT_UNTIL(rail_voltage_code[0] == 7'h15, 10)
		`CHK("sleep code", 7'h15, rail_voltage_code[0])
		`CHK("decay sel", 1'b1, rail_decay_select[0])
		`CHK("still on", 1'b1, rail_enable[0])
		@(posedge clk_sys) pin_req <= 6'h07;
		`WAIT_UNTIL(rail_voltage_code[0] == 7'h2A, 10)
		`CHK("wake code", 7'h2A, rail_voltage_code[0])
		wr(8'h10, 32'h00001533);
		@(posedge clk_sys) #1;
		`CHK("new code", 7'h33, rail_voltage_code[0])
	endtask : t_sleep

	task automatic t_off_paths();
		wr(8'h00, 32'h00001879);
		@(posedge clk_sys) pin_req <= 6'h06;
		`WAIT_UNTIL(!rail_enable[0], 150)
		`CHK("dis delay", 1'b1, !rail_enable[0] && cnt >= 2 * MS)
		wr(8'h02, 32'h00040078);
		`WAIT_UNTIL(rail_enable[2], 10)
		`CHK("sw on", 1'b1, rail_enable[2])
		wr(8'h02, 32'h000C0078);
		`WAIT_UNTIL(!rail_enable[2], 10)
		`CHK("sw off", 1'b0, rail_enable[2])
	endtask : t_off_paths

	task automatic t_pg_out();
		int t0;
		int t2;
		t0 = -1;
		t2 = -1;
		wr(8'h20, 32'h00014008);
		wr(8'h22, 32'h00000008);
		wr(8'h23, 32'h0000000C);
		wr(8'h03, 32'h00040078);
		for (int i = 0; i < 420; i++) begin
			@(posedge clk_sys);
			#1;
			if (general_output[0] && t0 < 0) t0 = i;
			if (general_output[2] && t2 < 0) t2 = i;
		end
		`CHK("out0 clamp", 1'b1, t0 >= 14 * MS && t0 <= 17 * MS)
		`CHK("out2 floor", 1'b1, t2 >= 4 * MS && t2 <= 7 * MS)
		`CHK("partial tree", 2'b00, {general_output[3], general_output[1]})
		wr(8'h02, 32'h00040078);
		`WAIT_UNTIL(general_output[3], 20)
		`CHK("full tree", 1'b1, general_output[3])
		wr(8'h24, 32'h00000023);
		@(posedge clk_sys) #1;
		`CHK("sw high", 4'hE, general_output)
		wr(8'h24, 32'h00000013);
		@(posedge clk_sys) #1;
		`CHK("sw low", 4'hD, general_output)
	endtask : t_pg_out

	task automatic t_uv();
		@(posedge clk_sys);
		supply_low <= 1'b1;
		supply_good <= 1'b0;
		`WAIT_UNTIL(device_mode == rps_pkg::ST_SHUT, 6)
		`CHK("pg drop", 4'h0, general_output)
		`CHK("rails held", 1'b1, rail_enable != 12'h000)
		`WAIT_UNTIL(rail_enable == 12'h000, 60)
		`CHK("uv holdoff", 1'b1, cnt >= 40 && rail_enable == 12'h000)
		`CHK("discharge", 1'b1, discharge_100ohm)
		@(posedge clk_sys) supply_low <= 1'b0;
		`WAIT_UNTIL(device_mode == rps_pkg::ST_OFF, 20)
		repeat (30) @(posedge clk_sys);
		#1;
		`CHK("off held", rps_pkg::ST_OFF, device_mode)
		`CHK("off rails", 12'h000, rail_enable)
		@(posedge clk_sys) supply_good <= 1'b1;
		`WAIT_UNTIL(device_mode == rps_pkg::ST_STANDBY, 40)
		rd(8'h03, rv);
		`CHK("uv reload", 32'h00000078, rv)
	endtask : t_uv

	task automatic t_therm();
		wr(8'h05, 32'h00040078);
		`WAIT_UNTIL(rail_enable[5], 10)
		@(posedge clk_sys) temp_critical <= 1'b1;
		`WAIT_UNTIL(device_mode == rps_pkg::ST_WAIT, 80)
		`CHK("hot off", 12'h000, rail_enable)
		@(posedge clk_sys) temp_critical <= 1'b0;
		repeat (30) @(posedge clk_sys);
		#1;
		`CHK("cool wait", rps_pkg::ST_WAIT, device_mode)
		@(posedge clk_sys) temp_cooled <= 1'b1;
		`WAIT_UNTIL(device_mode == rps_pkg::ST_STANDBY, 40)
		rd(8'h05, rv);
		`CHK("hot reload", 32'h00000078, rv)
		@(posedge clk_sys) temp_cooled <= 1'b0;
	endtask : t_therm

	task automatic t_fault();
		@(posedge clk_sys) pg_stuck <= 12'h010;
		wr(8'h04, 32'h00240078);
		`WAIT_UNTIL(device_mode == rps_pkg::ST_SHUT, 320)
		`CHK("pg timeout", 1'b1, cnt >= 9 * MS && cnt < 320)
		`WAIT_UNTIL(device_mode == rps_pkg::ST_STANDBY, 100)
		`CHK("fault rails", 12'h000, rail_enable)
		rd(8'h04, rv);
		`CHK("fault reload", 32'h00000078, rv)
		@(posedge clk_sys) pg_stuck <= 12'h000;
		wr(8'h04, 32'h00140078);
		repeat (12) @(posedge clk_sys);
		pg_stuck <= 12'h010;
		`WAIT_UNTIL(device_mode == rps_pkg::ST_SHUT, 10)
		`CHK("pg loss", rps_pkg::ST_SHUT, device_mode)
		`WAIT_UNTIL(device_mode == rps_pkg::ST_STANDBY, 100)
		@(posedge clk_sys) pg_stuck <= 12'h000;
	endtask : t_fault

	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		t_standby();
		t_seq();
		t_sleep();
		t_off_paths();
		t_pg_out();
		t_uv();
		t_therm();
		t_fault();
		tally_and_finish();
	end

	// hang guard, far beyond the fewer than two thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		tally_and_finish();
	end
endmodule : rail_power_sequencer_bench
`default_nettype wire
